// *** design/xoc_pkg.sv ***
package xoc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PWR     = 4'h0;
  localparam logic [3:0] ADDR_PLL     = 4'h1;
  localparam logic [3:0] ADDR_CAP     = 4'h2;
  localparam logic [3:0] ADDR_FREQ    = 4'h3;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_SET = 4'h5;
  localparam logic [3:0] ADDR_OFFSET  = 4'h6;
  localparam logic [3:0] ADDR_PLLWORD = 4'h7;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PWR_CLKCTL = 0;
  localparam int PWR_OSC    = 3;
  localparam int PWR_SYNTH  = 4;
  localparam int PWR_TX     = 5;
  localparam int PWR_RX     = 6;
  localparam int PLL_DITHER = 2;
  localparam int FREQ_EN    = 0;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0]  PWR_RST     = 8'h08;
  localparam logic [7:0]  PLL_RST     = 8'h00;
  localparam logic [3:0]  CAP_RST     = 4'h0;
  localparam logic [15:0] PLLWORD_RST = 16'h0000;
  localparam logic [7:0]  TAIL_PULSES = 8'hC0;
  localparam logic [7:0]  CAP_MIN_HALF_PF = 8'h11;
  localparam logic [4:0]  CLK_DIV_HALF = 5'h01;
  localparam logic [3:0]  CAL_CYCLES  = 4'hF;
  typedef enum logic [1:0] {XOC_OFF, XOC_RUN, XOC_TAIL} xoc_state_t;
endpackage : xoc_pkg

// *** design/xoc_tail_counter.sv ***
`timescale 1ns/10ps
module xoc_tail_counter (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic start,
  input  wire logic clk_fall,
  output logic      done
);
  import xoc_pkg::*;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  // counts whole output periods, one per falling edge of the host clock
  always_comb begin
    cnt_nxt = cnt_r;
    if (start) begin
      // a fall on the loading edge is already the first tail pulse
      cnt_nxt = clk_fall ? TAIL_PULSES - 8'h01 : TAIL_PULSES;
    end else if (clk_fall && cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) cnt_r <= 8'h00;
    else       cnt_r <= cnt_nxt;
  end
  assign done = (cnt_r == 8'h00);
endmodule : xoc_tail_counter

// *** design/xoc_clk_div.sv ***
`timescale 1ns/10ps
module xoc_clk_div (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      clk_out,
  output logic      fall
);
  import xoc_pkg::*;
  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic       ph_r;
  logic       ph_nxt;
  // stops only at low phase so no runt pulse leaves
  always_comb begin
    div_nxt = div_r;
    ph_nxt  = ph_r;
    fall    = 1'b0;
    if (run || ph_r) begin
      if (div_r == CLK_DIV_HALF) begin
        div_nxt = 5'h00;
        ph_nxt  = ~ph_r;
        fall    = ph_r;
      end else begin
        div_nxt = div_r + 5'h01;
      end
    end else begin
      div_nxt = 5'h00;
    end
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      div_r <= 5'h00;
      ph_r  <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ph_r  <= ph_nxt;
    end
  end
  assign clk_out = ph_r;
endmodule : xoc_clk_div

// *** design/xoc_top.sv ***
// Operation
// RL1: load cap code 0..15 maps to 8.5 pF plus 0.5 pF per step.
// RL2: clock output pin gated by clock output control, bit 0 of power word.
// RL3: clearing oscillator bit gives exactly 192 more output pulses.
// RL4: shutdown only if status was read first; host reads status first.
// RL5: any interrupt forces the oscillator on.
// RL6: interrupts cleared and status read turns oscillator off with tail.
// RL7: active interrupt keeps oscillator on despite oscillator bit clear.
// RL8: host reads status after power-on before writing oscillator bit zero.
// RL9: output disabled by control bit 0 turns off tail and auto wake.
// RL10: output disabled, rx and tx off: oscillator follows its bit only.
// RL11: transmitter bit 5 switches power amplifier on.
// RL12: synthesizer enabled while bit 4 of power word set.
// RL13: host keeps synthesizer on while transmitter or receiver on.
// RL14: host keeps oscillator on while synthesizer runs.
// RL15: synthesizer calibrates at power-up and each re-enable.
// RL16: host may recalibrate by toggling synthesizer after drift.
// RL17: dither on while pll bit 2 clear, off when set.
// RL18: with frequency control on, offset is added to pll control word.
// RL19: host may keep oscillator running for frequent radio use.
// RL20: tail counts output periods and stops only at low phase.
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module xoc_top (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [15:0]      rdata,
  input  wire logic        irq_in,
  output logic             host_clock_pin,
  output logic             crystal_osc_run,
  output logic [7:0]       load_cap_half_pf,
  output logic             synth_enable,
  output logic             synth_cal,
  output logic             pa_enable,
  output logic             pll_dither_en,
  output logic [15:0]      pll_ctrl_word
);
  import xoc_pkg::*;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  pwr_r, pwr_nxt;
  logic [7:0]  pll_r, pll_nxt;
  logic [3:0]  cap_r, cap_nxt;
  logic [7:0]  freq_r, freq_nxt;
  logic [15:0] base_r, base_nxt;
  logic signed [7:0] off_r, off_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        irq_s1_r, irq_s2_r, irq_s3_r;
  logic        irq_r, irq_nxt;
  logic        sw_irq_r, sw_irq_nxt;
  logic        stat_read_r, stat_read_nxt;
  logic        synth_d_r;
  logic [3:0]  cal_r, cal_nxt;
  xoc_state_t  st_r, st_nxt;
  logic        tail_start;
  logic        tail_done;
  logic        clk_fall;
  logic        clk_raw;
  logic        irq_any;
  logic        auto_on;
  logic        want_on;
  logic        out_dis;
  logic        stat_rd;
  logic [15:0] pll_sum;

  assign out_dis = pwr_r[PWR_CLKCTL];
  assign irq_any = irq_r | sw_irq_r;
  assign stat_rd = rd_en && addr == ADDR_STATUS;
  // auto wake only while output enabled
  assign auto_on = !out_dis && irq_any; // RL5 RL7 RL9 RL10
  assign want_on = pwr_r[PWR_OSC] | auto_on;

  // ---------------------------------------------------------------
  // bus and control registers
  // ---------------------------------------------------------------
  always_comb begin
    pwr_nxt  = pwr_r;
    pll_nxt  = pll_r;
    cap_nxt  = cap_r;
    freq_nxt = freq_r;
    base_nxt = base_r;
    off_nxt  = off_r;
    sw_irq_nxt = sw_irq_r;
    if (wr_en) begin
      case (addr)
        ADDR_PWR:     pwr_nxt  = wdata[7:0];
        ADDR_PLL:     pll_nxt  = wdata[7:0];
        ADDR_CAP:     cap_nxt  = wdata[3:0];
        ADDR_FREQ:    freq_nxt = wdata[7:0];
        ADDR_IRQ_SET: sw_irq_nxt = wdata[0];
        ADDR_OFFSET:  off_nxt  = wdata[7:0];
        ADDR_PLLWORD: base_nxt = wdata;
        default:      ;
      endcase
    end
    // status read clears latched interrupts, set wins
    irq_nxt = irq_r;
    if (stat_rd) begin
      irq_nxt    = 1'b0;
      sw_irq_nxt = (wr_en && addr == ADDR_IRQ_SET) ? wdata[0] : 1'b0;
    end
    if (irq_s2_r && irq_s3_r) irq_nxt = 1'b1;
    // status must be read after the last oscillator-on request
    stat_read_nxt = stat_read_r;
    if (stat_rd) stat_read_nxt = 1'b1;
    else if (wr_en && addr == ADDR_PWR && wdata[PWR_OSC]) stat_read_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    if (rd_en) begin
      case (addr)
        ADDR_PWR:     rdata_nxt = {8'h00, pwr_r};
        ADDR_PLL:     rdata_nxt = {8'h00, pll_r};
        ADDR_CAP:     rdata_nxt = {12'h000, cap_r};
        ADDR_FREQ:    rdata_nxt = {8'h00, freq_r};
        ADDR_STATUS:  rdata_nxt = {10'h000, synth_cal, crystal_osc_run,
                                   st_r == XOC_TAIL, stat_read_r, sw_irq_r, irq_r};
        ADDR_IRQ_SET: rdata_nxt = {15'h0000, sw_irq_r};
        ADDR_OFFSET:  rdata_nxt = {{8{off_r[7]}}, off_r};
        ADDR_PLLWORD: rdata_nxt = pll_ctrl_word;
        default:      rdata_nxt = 16'h0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // oscillator and clock tail
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt     = st_r;
    tail_start = 1'b0;
    case (st_r)
      XOC_OFF: if (want_on) st_nxt = XOC_RUN;
      XOC_RUN: begin
        if (!want_on) begin
          if (out_dis) begin
            st_nxt = XOC_OFF; // RL9 RL10
          end else if (stat_read_r) begin // RL4 RL6
            st_nxt     = XOC_TAIL;
            tail_start = 1'b1; // RL3
          end
        end
      end
      XOC_TAIL: begin
        if (want_on) st_nxt = XOC_RUN;
        else if (tail_done) st_nxt = XOC_OFF; // RL3
      end
      default: st_nxt = XOC_OFF;
    endcase
  end

  // ---------------------------------------------------------------
  // synthesizer, calibration, pll word
  // ---------------------------------------------------------------
  always_comb begin
    cal_nxt = cal_r;
    // rising enable restarts calibration
    if (pwr_r[PWR_SYNTH] && !synth_d_r) cal_nxt = CAL_CYCLES; // RL15
    else if (cal_r != 4'h0) cal_nxt = cal_r - 4'h1;
  end
  assign pll_sum = base_r + {{8{off_r[7]}}, off_r}; // RL18

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pwr_r       <= PWR_RST;
      pll_r       <= PLL_RST;
      cap_r       <= CAP_RST;
      freq_r      <= 8'h00;
      base_r      <= PLLWORD_RST;
      off_r       <= 8'h00;
      rdata_r     <= 16'h0000;
      irq_s1_r    <= 1'b0;
      irq_s2_r    <= 1'b0;
      irq_s3_r    <= 1'b0;
      irq_r       <= 1'b1;
      sw_irq_r    <= 1'b0;
      stat_read_r <= 1'b0;
      synth_d_r   <= 1'b0;
      cal_r       <= 4'h0;
      st_r        <= XOC_RUN;
    end else begin
      pwr_r       <= pwr_nxt;
      pll_r       <= pll_nxt;
      cap_r       <= cap_nxt;
      freq_r      <= freq_nxt;
      base_r      <= base_nxt;
      off_r       <= off_nxt;
      rdata_r     <= rdata_nxt;
      irq_s1_r    <= irq_in;
      irq_s2_r    <= irq_s1_r;
      irq_s3_r    <= irq_s2_r;
      irq_r       <= irq_nxt;
      sw_irq_r    <= sw_irq_nxt;
      stat_read_r <= stat_read_nxt;
      synth_d_r   <= pwr_r[PWR_SYNTH];
      cal_r       <= cal_nxt;
      st_r        <= st_nxt;
    end
  end

  xoc_clk_div u_div (
    .mclk    (mclk),
    .nrst    (nrst),
    .run     (st_r != XOC_OFF),
    .clk_out (clk_raw),
    .fall    (clk_fall)
  );

  xoc_tail_counter u_tail (
    .mclk     (mclk),
    .nrst     (nrst),
    .start    (tail_start),
    .clk_fall (clk_fall), // RL20
    .done     (tail_done)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata            = rdata_r;
  assign host_clock_pin   = clk_raw & !out_dis; // RL2
  assign crystal_osc_run  = st_r != XOC_OFF;
  assign load_cap_half_pf = CAP_MIN_HALF_PF + {4'h0, cap_r}; // RL1
  assign synth_enable     = pwr_r[PWR_SYNTH]; // RL12
  assign synth_cal        = cal_r != 4'h0;
  assign pa_enable        = pwr_r[PWR_TX]; // RL11
  assign pll_dither_en    = !pll_r[PLL_DITHER]; // RL17
  assign pll_ctrl_word    = freq_r[FREQ_EN] ? pll_sum : base_r; // RL18

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_irq_keeps;
    @(posedge mclk) disable iff (!nrst) (auto_on && st_r == XOC_RUN) |=> st_r == XOC_RUN;
  endproperty
  a_irq_keeps: assert property (p_irq_keeps) else $error("osc stopped with irq"); // RL7
  property p_dither;
    @(posedge mclk) disable iff (!nrst)
      (wr_en && addr == ADDR_PLL) |=> pll_dither_en == !$past(wdata[PLL_DITHER]);
  endproperty
  a_dither: assert property (p_dither) else $error("dither mismatch"); // RL17
  property p_no_read_no_tail;
    @(posedge mclk) disable iff (!nrst)
      (st_r == XOC_RUN && !stat_read_r && !out_dis) |=> st_r != XOC_TAIL;
  endproperty
  a_no_read_no_tail: assert property (p_no_read_no_tail) else $error("tail without read"); // RL4
  property p_dis_off;
    @(posedge mclk) disable iff (!nrst) out_dis |-> !host_clock_pin;
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("clock out while disabled"); // RL2
  property p_cal;
    @(posedge mclk) disable iff (!nrst) $rose(synth_d_r) |-> synth_cal;
  endproperty
  a_cal: assert property (p_cal) else $error("no calibration"); // RL15
  property p_wake;
    @(posedge mclk) disable iff (!nrst) (auto_on && st_r == XOC_OFF) |=> crystal_osc_run;
  endproperty
  a_wake: assert property (p_wake) else $error("no auto wake"); // RL5
  sequence s_tail_go;
    tail_start;
  endsequence
  sequence s_tail_hold;
    (st_r == XOC_TAIL || want_on) [*8];
  endsequence
  property p_tail_len;
    @(posedge mclk) disable iff (!nrst) s_tail_go |=> s_tail_hold;
  endproperty
  a_tail_len: assert property (p_tail_len) else $error("tail cut short"); // RL3
  // stop lands in the low phase, right after the last fall
  sequence s_tail_end;
    st_r == XOC_TAIL && tail_done;
  endsequence
  property p_tail_low;
    @(posedge mclk) disable iff (!nrst) s_tail_end |=> !host_clock_pin && st_r != XOC_TAIL;
  endproperty
  a_tail_low: assert property (p_tail_low) else $error("tail ended high"); // RL20
  property p_pa;
    @(posedge mclk) disable iff (!nrst)
      (wr_en && addr == ADDR_PWR) |=> pa_enable == $past(wdata[PWR_TX]);
  endproperty
  a_pa: assert property (p_pa) else $error("pa mismatch"); // RL11
  property p_synth;
    @(posedge mclk) disable iff (!nrst)
      (wr_en && addr == ADDR_PWR) |=> synth_enable == $past(wdata[PWR_SYNTH]);
  endproperty
  a_synth: assert property (p_synth) else $error("synthesizer enable mismatch"); // RL12
  // no tail and no interrupt hold once the output is disabled
  property p_dis_stop;
    @(posedge mclk) disable iff (!nrst)
      (st_r == XOC_RUN && out_dis && !pwr_r[PWR_OSC]) |=> st_r == XOC_OFF;
  endproperty
  a_dis_stop: assert property (p_dis_stop) else $error("osc held with output off"); // RL9 RL10
  property p_cap_map;
    @(posedge mclk) disable iff (!nrst)
      (wr_en && addr == ADDR_CAP) |=>
        load_cap_half_pf == CAP_MIN_HALF_PF + {4'h0, $past(wdata[3:0])};
  endproperty
  a_cap_map: assert property (p_cap_map) else $error("load cap code mismatch"); // RL1
  property p_irq_latch;
    @(posedge mclk) disable iff (!nrst) (irq_s2_r && irq_s3_r) |=> irq_r;
  endproperty
  a_irq_latch: assert property (p_irq_latch) else $error("interrupt not latched"); // RL5
endmodule : xoc_top

// *** tb/xoc_host_model.sv ***
`timescale 1ns/10ps
module xoc_host_model (
  input  wire logic        host_clock_pin,
  output logic [15:0]      pulses
);
  // ---------------------------------------------------------------
  // host side: counts every clock it is given
  // ---------------------------------------------------------------
  // only falling edges counted, so a clipped high phase still shows up
  initial pulses = 16'h0000;
  always @(negedge host_clock_pin) begin
    pulses <= pulses + 16'h0001;
  end
endmodule : xoc_host_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import xoc_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        irq_in = 1'b0;
  logic        rd_d = 1'b0;
  logic [15:0] rdata, pll_ctrl_word, pulses, snap, base, off;
  logic [7:0]  load_cap_half_pf;
  logic        host_clock_pin, crystal_osc_run, synth_enable, synth_cal;
  logic        pa_enable, pll_dither_en, seen;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  int          mismatches = 0;
  int          tests_run = 0;
  int          n;
  integer      seed = 32'hB303;
  // ---------------------------------------------------------------
  // clock, design, host
  // ---------------------------------------------------------------
  always #12.5 mclk = ~mclk;
  xoc_top DUT (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .irq_in(irq_in), .host_clock_pin(host_clock_pin),
    .crystal_osc_run(crystal_osc_run), .load_cap_half_pf(load_cap_half_pf),
    .synth_enable(synth_enable), .synth_cal(synth_cal), .pa_enable(pa_enable),
    .pll_dither_en(pll_dither_en), .pll_ctrl_word(pll_ctrl_word));
  xoc_host_model host (.host_clock_pin(host_clock_pin), .pulses(pulses));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    tests_run++;
    if (s !== x) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic end_sim();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // bit 16 of the note marks a read whose value is not predicted
  task automatic rd(input logic [3:0] a, input logic [16:0] x);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(x);
    @(posedge mclk);
    rd_en <= 1'b0;
  endtask : rd
  task automatic wosc(input logic v, input int lim);
    n = 0;
    while (crystal_osc_run !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    if (crystal_osc_run !== v) begin
      mismatches++;
      end_sim();
    end
  endtask : wosc
  task automatic tail_chk();
    // let the request edge settle so only later falls count
    @(negedge mclk);
    snap = pulses;
    wosc(1'b0, 2000);
    repeat (8) @(negedge mclk);
    chk(pulses - snap, 16'(TAIL_PULSES));
    chk(16'(host_clock_pin), 16'h0000);
  endtask : tail_chk
  task automatic cal_chk();
    n = 0;
    repeat (40) begin
      @(negedge mclk);
      if (synth_cal === 1'b1) n++;
    end
    chk(16'(n), 16'h000F);
  endtask : cal_chk
  // ---------------------------------------------------------------
  // read monitor: oldest note against the data of the cycle after
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd_d && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (!e[16]) chk(rdata, e[15:0]);
    end
    rd_d <= rd_en;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_PWR, 17'h00008);
    rd(ADDR_PLL, 17'h00000);
    rd(ADDR_CAP, 17'h00000);
    rd(4'hF, 17'h00000);
    for (int i = 0; i < 17; i++) begin
      n = (i == 16) ? ($random(seed) & 15) : i;
      wr(ADDR_CAP, 16'(n));
      @(negedge mclk);
      chk(16'(load_cap_half_pf), 16'(n) + 16'h0011);
    end
    rd(ADDR_CAP, {1'b0, 16'(n)});
    wr(ADDR_PLL, 16'h0004);
    @(negedge mclk);
    chk(16'(pll_dither_en), 16'h0000);
    wr(ADDR_PLL, 16'h0000);
    @(negedge mclk);
    chk(16'(pll_dither_en), 16'h0001);
    repeat (3) begin
      base = 16'h1000 + 16'($random(seed) & 16'h7FFF);
      off  = 16'(signed'(8'($random(seed))));
      wr(ADDR_PLLWORD, base);
      wr(ADDR_OFFSET, off);
      wr(ADDR_FREQ, 16'h0001);
      @(negedge mclk);
      chk(pll_ctrl_word, base + off);
      wr(ADDR_FREQ, 16'h0000);
      @(negedge mclk);
      chk(pll_ctrl_word, base);
    end
    // oscillator stays on under the synthesizer throughout
    wr(ADDR_PWR, 16'h0018);
    @(negedge mclk);
    chk(16'(synth_enable), 16'h0001);
    cal_chk();
    wr(ADDR_PWR, 16'h0038);
    @(negedge mclk);
    chk(16'(pa_enable), 16'h0001);
    wr(ADDR_PWR, 16'h0008);
    @(negedge mclk);
    chk(16'({synth_enable, pa_enable}), 16'h0000);
    wr(ADDR_PWR, 16'h0018);
    cal_chk();
    wr(ADDR_PWR, 16'h0008);
    rd(ADDR_STATUS, 17'h00011);
    wr(ADDR_PWR, 16'h0008);
    wr(ADDR_PWR, 16'h0000);
    repeat (60) @(negedge mclk);
    chk(16'(crystal_osc_run), 16'h0001);
    rd(ADDR_STATUS, 17'h00010);
    tail_chk();
    wr(ADDR_PWR, 16'h0008);
    wosc(1'b1, 20);
    rd(ADDR_STATUS, 17'h10000);
    wr(ADDR_PWR, 16'h0000);
    tail_chk();
    irq_in <= 1'b1;
    wosc(1'b1, 20);
    wr(ADDR_PWR, 16'h0000);
    repeat (50) @(negedge mclk);
    chk(16'(crystal_osc_run), 16'h0001);
    irq_in <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(ADDR_STATUS, 17'h10000);
    tail_chk();
    // software interrupt wakes the oscillator as well
    wr(ADDR_IRQ_SET, 16'h0001);
    wosc(1'b1, 20);
    rd(ADDR_STATUS, 17'h00016);
    tail_chk();
    // output disabled: no pin activity, no tail, interrupts ignored
    wr(ADDR_PWR, 16'h0009);
    snap = pulses;
    seen = 1'b0;
    repeat (40) begin
      @(negedge mclk);
      seen = seen | host_clock_pin;
    end
    chk(16'(seen), 16'h0000);
    chk(16'(crystal_osc_run), 16'h0001);
    wr(ADDR_PWR, 16'h0001);
    wosc(1'b0, 10);
    chk(pulses - snap, 16'h0000);
    irq_in <= 1'b1;
    repeat (20) @(negedge mclk);
    chk(16'(crystal_osc_run), 16'h0000);
    irq_in <= 1'b0;
    wr(ADDR_PWR, 16'h0008);
    snap = pulses;
    repeat (40) @(negedge mclk);
    chk(16'(pulses != snap), 16'h0001);
    end_sim();
  end
endmodule : tb_top
